//--- inc/sscm_pkg.sv
// Constants and types for the standby and subclock mode controller.
// Assumes a single 40 MHz system clock domain.
package sscm_pkg;
  // ****************************************************************
  // Register offsets (APB byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFS_CLOCK_CONTROL = 8'h00;
  localparam logic [7:0] OFS_POWER_SAVE = 8'h04;
  localparam logic [7:0] OFS_STAB_SELECT = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_PERIPH_CFG = 8'h10;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int DIVIDER_LSB = 0;
  localparam int SUBCLOCK_SELECT_POS = 3;
  localparam int MAIN_CLOCK_STOP_POS = 4;
  localparam int POWER_SAVE_MODE_POS = 0;
  localparam int STANDBY_TRIGGER_POS = 1;
  localparam int STOP_TRIGGER_POS = 2;
  // Peripheral configuration bits
  localparam int CFG_T16_SRC_WATCH = 0;
  localparam int CFG_WATCH_ON_SUB = 1;
  localparam int CFG_T8_SRC_PIN = 2;
  localparam int CFG_T8_SRC_T16 = 3;
  localparam int CFG_T16_ENABLED = 4;
  localparam int CFG_RTO_TRIG_T8 = 5;
  localparam int CFG_TH_ON_SUB = 6;
  localparam int CFG_WDT2_ON_SUB = 7;
  localparam int CFG_CSI_EXT_CLK = 8;
  localparam int CFG_UART_EXT_CLK = 9;
  localparam int NUM_CFG = 10;
  // ****************************************************************
  // Reset values and timing
  // ****************************************************************
  localparam logic [2:0] STAB_SELECT_RESET = 3'h5;
  localparam int STAB_RESET_EXP = 15;
  localparam int STAB_MIN_EXP = 10;
  localparam int STAB_CNT_W = 20;
  localparam int NUM_GATES = 8;
  localparam int GATE_T16 = 0;
  localparam int GATE_T8 = 1;
  localparam int GATE_RTO = 2;
  localparam int GATE_TH = 3;
  localparam int GATE_WDT2 = 4;
  localparam int GATE_CSI = 5;
  localparam int GATE_UART = 6;
  localparam int GATE_OTHER = 7;
  typedef enum logic [2:0] {
    SSCM_NORMAL, SSCM_SUB, SSCM_SUB_IDLE, SSCM_STOP, SSCM_STAB
  } sscm_mode_t;
endpackage

//--- inc/sscm_if.sv
// Link between the mode controller and the core-side wake logic.
// Assumes both ends share mclk.
`timescale 1ns/10ps
interface sscm_if;
  logic cpu_clk_en;
  logic periph_clk_en;
  logic sys_on_sub;
  logic main_osc_run;
  logic [7:0] gate_en;
  logic nmi_pin;
  logic wdt2_int;
  logic ext_int;
  logic periph_int;
  logic reset_req;
  logic wdt1_reset;
  logic wdt2_reset;
  modport device (
    output cpu_clk_en, output periph_clk_en, output sys_on_sub,
    output main_osc_run, output gate_en,
    input nmi_pin, input wdt2_int, input ext_int, input periph_int,
    input reset_req, input wdt1_reset, input wdt2_reset
  );
  modport host (
    input cpu_clk_en, input periph_clk_en, input sys_on_sub,
    input main_osc_run, input gate_en,
    output nmi_pin, output wdt2_int, output ext_int, output periph_int,
    output reset_req, output wdt1_reset, output wdt2_reset
  );
endinterface // sscm_if

//--- logic/sscm_device.sv
// Power mode controller: stabilization wait, subclock mode, sub-idle.
// Assumes APB software access and wake/reset sources via sscm_if.
// Functional notes
// - Interrupt stop release waits programmed stabilization time
// - Reset stop release waits two to fifteen
// - Subclock select bit moves system to subclock
// - Main clock stop bit halts main oscillator in subclock modes
// - Software keeps divided clock above four subclocks
// - Software changes select bit without touching divider
// - Clear select or reset returns normal mode
// - Software restarts oscillator and waits before clearing
// - Sixteen-bit timer needs watch source on subclock
// - Eight-bit timer needs pin or enabled timer
// - Real-time output needs pin-clocked eight-bit trigger
// - Timer h and watchdog need subclock source
// - Serial channels need external clocks
// - Clear mode select, set trigger: sub-idle
// - Sub-idle gates CPU, peripherals; oscillators keep their state
// - Software adds five no-ops after entry store
// - Listed interrupts and resets release sub-idle
// - Interrupt resumes subclock; reset restarts normal
// - Lower priority wake leaves request pending
`timescale 1ns/10ps
module sscm_device #(
  parameter int STAB_CNT_W = sscm_pkg::STAB_CNT_W
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  sscm_if.device lnk
);
  // ****************************************************************
  // Registers and state
  // ****************************************************************
  logic [2:0] clock_divider;
  logic subclock_select_bit;
  logic main_clock_stop_bit;
  logic power_save_mode_select;
  logic [2:0] stabilization_time_select;
  logic [sscm_pkg::NUM_CFG-1:0] periph_cfg;
  sscm_pkg::sscm_mode_t mode;
  sscm_pkg::sscm_mode_t next_mode;
  logic [STAB_CNT_W-1:0] stab_cnt;
  logic [STAB_CNT_W-1:0] stab_target;
  logic [STAB_CNT_W-1:0] next_target;
  logic wake_q1;
  logic wake_q2;
  logic rst_q1;
  logic rst_q2;
  logic [7:0] next_gate;
  logic wr;
  logic any_reset;
  logic wake_irq;

  assign wr = psel & penable & pwrite & pready;

  function automatic logic [STAB_CNT_W-1:0] stab_len(input logic [2:0] sel);
    stab_len = STAB_CNT_W'(1) << (sscm_pkg::STAB_MIN_EXP + int'(sel));
  endfunction

  // ****************************************************************
  // Input synchronisers for wake and reset sources
  // ****************************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wake_q1 <= 1'b0;
      wake_q2 <= 1'b0;
      rst_q1 <= 1'b0;
      rst_q2 <= 1'b0;
    end else if (clk_en) begin
      wake_q1 <= lnk.nmi_pin | lnk.ext_int | lnk.periph_int
        | (lnk.wdt2_int & lnk.sys_on_sub);
      wake_q2 <= wake_q1;
      rst_q1 <= lnk.reset_req | lnk.wdt1_reset | lnk.wdt2_reset;
      rst_q2 <= rst_q1;
    end
  end
  assign wake_irq = wake_q2;
  assign any_reset = rst_q2;

  // ****************************************************************
  // APB slave
  // ****************************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (clk_en) begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~(paddr == sscm_pkg::OFS_CLOCK_CONTROL
        || paddr == sscm_pkg::OFS_POWER_SAVE || paddr == sscm_pkg::OFS_STAB_SELECT
        || paddr == sscm_pkg::OFS_STATUS || paddr == sscm_pkg::OFS_PERIPH_CFG);
      if (psel & ~penable & ~pwrite) begin
        case (paddr)
          sscm_pkg::OFS_CLOCK_CONTROL: prdata <= {27'h0, main_clock_stop_bit,
            subclock_select_bit, clock_divider};
          sscm_pkg::OFS_POWER_SAVE: prdata <= {31'h0, power_save_mode_select};
          sscm_pkg::OFS_STAB_SELECT: prdata <= {29'h0, stabilization_time_select};
          sscm_pkg::OFS_STATUS: prdata <= {29'h0, mode};
          sscm_pkg::OFS_PERIPH_CFG: prdata <= {22'h0, periph_cfg};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      clock_divider <= 3'h0;
      subclock_select_bit <= 1'b0;
      main_clock_stop_bit <= 1'b0;
      power_save_mode_select <= 1'b1;
      stabilization_time_select <= sscm_pkg::STAB_SELECT_RESET;
      periph_cfg <= '0;
    end else if (clk_en) begin
      if (any_reset) begin
        subclock_select_bit <= 1'b0;
        main_clock_stop_bit <= 1'b0;
        stabilization_time_select <= sscm_pkg::STAB_SELECT_RESET;
      end else if (wr) begin
        case (paddr)
          sscm_pkg::OFS_CLOCK_CONTROL: begin
            clock_divider <= pwdata[sscm_pkg::DIVIDER_LSB +: 3];
            subclock_select_bit <= pwdata[sscm_pkg::SUBCLOCK_SELECT_POS];
            main_clock_stop_bit <= pwdata[sscm_pkg::MAIN_CLOCK_STOP_POS];
          end
          sscm_pkg::OFS_POWER_SAVE:
            power_save_mode_select <= pwdata[sscm_pkg::POWER_SAVE_MODE_POS];
          sscm_pkg::OFS_STAB_SELECT: stabilization_time_select <= pwdata[2:0];
          sscm_pkg::OFS_PERIPH_CFG: periph_cfg <= pwdata[sscm_pkg::NUM_CFG-1:0];
          default: ;
        endcase
      end
    end
  end

  // ****************************************************************
  // Mode sequencer
  // ****************************************************************
  always_comb begin
    next_mode = mode;
    next_target = stab_target;
    case (mode)
      sscm_pkg::SSCM_NORMAL: begin
        if (wr && paddr == sscm_pkg::OFS_CLOCK_CONTROL
            && pwdata[sscm_pkg::SUBCLOCK_SELECT_POS])
          next_mode = sscm_pkg::SSCM_SUB;
        else if (wr && paddr == sscm_pkg::OFS_POWER_SAVE
            && pwdata[sscm_pkg::STOP_TRIGGER_POS])
          next_mode = sscm_pkg::SSCM_STOP;
      end
      sscm_pkg::SSCM_SUB: begin
        if (wr && paddr == sscm_pkg::OFS_CLOCK_CONTROL
            && !pwdata[sscm_pkg::SUBCLOCK_SELECT_POS])
          next_mode = sscm_pkg::SSCM_NORMAL;
        else if (wr && paddr == sscm_pkg::OFS_POWER_SAVE
            && !pwdata[sscm_pkg::POWER_SAVE_MODE_POS]
            && pwdata[sscm_pkg::STANDBY_TRIGGER_POS])
          next_mode = sscm_pkg::SSCM_SUB_IDLE;
      end
      sscm_pkg::SSCM_SUB_IDLE: begin
        if (wake_irq)
          next_mode = sscm_pkg::SSCM_SUB;
      end
      sscm_pkg::SSCM_STOP: begin
        if (wake_irq) begin
          next_mode = sscm_pkg::SSCM_STAB;
          next_target = stab_len(stabilization_time_select);
        end
      end
      sscm_pkg::SSCM_STAB: begin
        if (stab_cnt >= stab_target - STAB_CNT_W'(1))
          next_mode = sscm_pkg::SSCM_NORMAL;
      end
      default: next_mode = sscm_pkg::SSCM_NORMAL;
    endcase
    if (any_reset) begin
      if (mode == sscm_pkg::SSCM_STOP) begin
        next_mode = sscm_pkg::SSCM_STAB;
        next_target = STAB_CNT_W'(1) << sscm_pkg::STAB_RESET_EXP;
      end else if (mode != sscm_pkg::SSCM_STAB) begin
        next_mode = sscm_pkg::SSCM_NORMAL;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode <= sscm_pkg::SSCM_NORMAL;
      stab_target <= '0;
    end else if (clk_en) begin
      mode <= next_mode;
      stab_target <= next_target;
    end
  end

  // Counts main oscillator cycles from the release event
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stab_cnt <= '0;
    end else if (clk_en) begin
      if (mode == sscm_pkg::SSCM_STAB)
        stab_cnt <= stab_cnt + STAB_CNT_W'(1);
      else
        stab_cnt <= '0;
    end
  end

  // ****************************************************************
  // Clock gating outputs
  // ****************************************************************
  always_comb begin
    next_gate = '1;
    if (mode == sscm_pkg::SSCM_SUB && main_clock_stop_bit) begin
      next_gate[sscm_pkg::GATE_T16] = periph_cfg[sscm_pkg::CFG_T16_SRC_WATCH]
        & periph_cfg[sscm_pkg::CFG_WATCH_ON_SUB];
      next_gate[sscm_pkg::GATE_T8] = periph_cfg[sscm_pkg::CFG_T8_SRC_PIN]
        | (periph_cfg[sscm_pkg::CFG_T8_SRC_T16]
        & periph_cfg[sscm_pkg::CFG_T16_ENABLED]);
      next_gate[sscm_pkg::GATE_RTO] = periph_cfg[sscm_pkg::CFG_RTO_TRIG_T8]
        & periph_cfg[sscm_pkg::CFG_T8_SRC_PIN];
      next_gate[sscm_pkg::GATE_TH] = periph_cfg[sscm_pkg::CFG_TH_ON_SUB];
      next_gate[sscm_pkg::GATE_WDT2] = periph_cfg[sscm_pkg::CFG_WDT2_ON_SUB];
      next_gate[sscm_pkg::GATE_CSI] = periph_cfg[sscm_pkg::CFG_CSI_EXT_CLK];
      next_gate[sscm_pkg::GATE_UART] = periph_cfg[sscm_pkg::CFG_UART_EXT_CLK];
      next_gate[sscm_pkg::GATE_OTHER] = 1'b0;
    end else if (mode == sscm_pkg::SSCM_SUB_IDLE) begin
      next_gate = '0;
      next_gate[sscm_pkg::GATE_TH] = periph_cfg[sscm_pkg::CFG_TH_ON_SUB];
      next_gate[sscm_pkg::GATE_WDT2] = periph_cfg[sscm_pkg::CFG_WDT2_ON_SUB];
      next_gate[sscm_pkg::GATE_CSI] = periph_cfg[sscm_pkg::CFG_CSI_EXT_CLK];
      next_gate[sscm_pkg::GATE_UART] = periph_cfg[sscm_pkg::CFG_UART_EXT_CLK];
      next_gate[sscm_pkg::GATE_T8] = periph_cfg[sscm_pkg::CFG_T8_SRC_PIN];
    end else if (mode == sscm_pkg::SSCM_STOP || mode == sscm_pkg::SSCM_STAB) begin
      next_gate = '0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lnk.cpu_clk_en <= 1'b1;
      lnk.periph_clk_en <= 1'b1;
      lnk.sys_on_sub <= 1'b0;
      lnk.main_osc_run <= 1'b1;
      lnk.gate_en <= '1;
    end else if (clk_en) begin
      lnk.cpu_clk_en <= next_mode == sscm_pkg::SSCM_NORMAL
        || next_mode == sscm_pkg::SSCM_SUB;
      lnk.periph_clk_en <= next_mode == sscm_pkg::SSCM_NORMAL
        || next_mode == sscm_pkg::SSCM_SUB;
      lnk.sys_on_sub <= next_mode == sscm_pkg::SSCM_SUB
        || next_mode == sscm_pkg::SSCM_SUB_IDLE;
      lnk.main_osc_run <= !(main_clock_stop_bit && (next_mode == sscm_pkg::SSCM_SUB
        || next_mode == sscm_pkg::SSCM_SUB_IDLE))
        && next_mode != sscm_pkg::SSCM_STOP;
      lnk.gate_en <= next_gate;
    end
  end
endmodule // sscm_device

//--- logic/sscm_host.sv
// Core-side wake and reset source logic driving the controller link.
// Assumes raw pins come from outside the mclk domain.
`timescale 1ns/10ps
module sscm_host (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic nmi_in,
  input wire logic wdt2_int_in,
  input wire logic [7:0] ext_int_in,
  input wire logic [7:0] ext_int_mask,
  input wire logic periph_int_in,
  input wire logic reset_in,
  input wire logic wdt1_reset_in,
  input wire logic wdt2_reset_in,
  output logic cpu_running,
  output logic on_subclock,
  sscm_if.host lnk
);
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [13:0] raw;
  logic [13:0] sync1;
  logic [13:0] sync2;
  assign raw = {nmi_in, wdt2_int_in, periph_int_in, reset_in, wdt1_reset_in,
    wdt2_reset_in, ext_int_in & ~ext_int_mask};
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync1 <= '0;
      sync2 <= '0;
    end else if (clk_en) begin
      sync1 <= raw;
      sync2 <= sync1;
    end
  end

  // ****************************************************************
  // Link drive
  // ****************************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lnk.nmi_pin <= 1'b0;
      lnk.wdt2_int <= 1'b0;
      lnk.periph_int <= 1'b0;
      lnk.reset_req <= 1'b0;
      lnk.wdt1_reset <= 1'b0;
      lnk.wdt2_reset <= 1'b0;
      lnk.ext_int <= 1'b0;
      cpu_running <= 1'b1;
      on_subclock <= 1'b0;
    end else if (clk_en) begin
      lnk.nmi_pin <= sync2[13];
      lnk.wdt2_int <= sync2[12];
      lnk.periph_int <= sync2[11];
      lnk.reset_req <= sync2[10];
      lnk.wdt1_reset <= sync2[9];
      lnk.wdt2_reset <= sync2[8] & lnk.sys_on_sub;
      lnk.ext_int <= |sync2[7:0];
      cpu_running <= lnk.cpu_clk_en;
      on_subclock <= lnk.sys_on_sub;
    end
  end
endmodule // sscm_host

//--- tb/sscm_properties.sv
// Concurrent checks on the link between the mode controller and the wake logic.
// Assumes one mclk domain; instantiated beside sscm_if in the bench top.
`timescale 1ns/10ps
module sscm_properties (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  input wire logic sys_on_sub,
  input wire logic main_osc_run,
  input wire logic [7:0] gate_en,
  input wire logic nmi_pin,
  input wire logic wdt2_int,
  input wire logic ext_int,
  input wire logic periph_int,
  input wire logic reset_req,
  input wire logic wdt1_reset,
  input wire logic wdt2_reset
);
  localparam int STAB_MIN = (1 << sscm_pkg::STAB_MIN_EXP) - 4;
  logic [19:0] osc_cnt;
  logic stop_seen;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // ************************************************
  // Stabilization cycle counter
  // ************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      osc_cnt <= 20'h0;
    end else if (cpu_clk_en || !main_osc_run) begin
      osc_cnt <= 20'h0;
    end else if (osc_cnt != 20'hfffff) begin
      osc_cnt <= osc_cnt + 20'h1;
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stop_seen <= 1'b0;
    end else if (cpu_clk_en) begin
      stop_seen <= 1'b0;
    end else if (!main_osc_run && !sys_on_sub) begin
      stop_seen <= 1'b1;
    end
  end
  // ************************************************
  // Properties
  // ************************************************
  sequence idle_s;
    sys_on_sub && !cpu_clk_en;
  endsequence
  sequence wake_s;
    $rose(nmi_pin || wdt2_int || ext_int || periph_int) && !reset_req && !wdt2_reset;
  endsequence
  sequence reset_s;
    $rose(reset_req || wdt1_reset || wdt2_reset);
  endsequence
  stab_wait_a:
    assert property ($rose(cpu_clk_en) && stop_seen |-> osc_cnt >= STAB_MIN)
      else $error("CPU clock resumed before stabilization count expired");
  sub_entry_a:
    assert property ($rose(sys_on_sub) |-> $past(cpu_clk_en))
      else $error("Subclock entered while not in normal operation");
  osc_only_sub_a:
    assert property (cpu_clk_en && !main_osc_run |-> sys_on_sub)
      else $error("CPU clocked with main oscillator off outside subclock mode");
  main_stop_gates_a:
    assert property (sys_on_sub && !main_osc_run |-> !gate_en[sscm_pkg::GATE_OTHER])
      else $error("Main-clock-only peripherals clocked with main oscillator off");
  idle_gating_a:
    assert property (idle_s |-> !periph_clk_en)
      else $error("Peripheral clock running in sub-idle");
  idle_osc_a:
    assert property ($fell(cpu_clk_en) && sys_on_sub |-> main_osc_run == $past(main_osc_run))
      else $error("Oscillator state changed on sub-idle entry");
  idle_wake_a:
    assert property (idle_s ##0 wake_s |-> ##[1:8] (cpu_clk_en && sys_on_sub))
      else $error("Sub-idle not left to subclock mode after wake request");
  idle_reset_a:
    assert property (idle_s ##0 reset_s |-> ##[1:8] !sys_on_sub)
      else $error("Sub-idle not left to normal mode after reset");
  sub_reset_a:
    assert property (sys_on_sub && cpu_clk_en ##0 reset_s |-> ##[1:8] !sys_on_sub)
      else $error("Subclock mode kept after reset");
endmodule // sscm_properties

//--- tb/test_standby_subclock_mode_control.sv
// Self-checking bench: controller and wake logic joined by sscm_if.
// Assumes APB access to the controller and 40 MHz mclk.
`timescale 1ns/10ps
module test_standby_subclock_mode_control;
  logic mclk, rst, clk_en, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0] paddr, src;
  logic [31:0] pwdata, prdata, rdat;
  logic cpu_running, on_subclock;
  int fails, total_checks, n;
  logic [9:0] cfgs [10] = '{10'h000, 10'h3ff, 10'h001, 10'h003, 10'h004, 10'h018, 10'h010,
    10'h024, 10'h020, 10'h3c0};
  sscm_if lk();
  sscm_device sscm_device_i (.mclk(mclk), .rst(rst), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lnk(lk));
  sscm_host sscm_host_i (.mclk(mclk), .rst(rst), .clk_en(clk_en), .nmi_in(src[0]),
    .wdt2_int_in(src[1]), .ext_int_in({6'h0, src[7], src[2]}), .ext_int_mask(8'h02),
    .periph_int_in(src[3]), .reset_in(src[4]), .wdt1_reset_in(src[5]),
    .wdt2_reset_in(src[6]), .cpu_running(cpu_running), .on_subclock(on_subclock), .lnk(lk));
  sscm_properties sscm_properties_i (.mclk(mclk), .rst(rst), .cpu_clk_en(lk.cpu_clk_en),
    .periph_clk_en(lk.periph_clk_en), .sys_on_sub(lk.sys_on_sub),
    .main_osc_run(lk.main_osc_run), .gate_en(lk.gate_en), .nmi_pin(lk.nmi_pin),
    .wdt2_int(lk.wdt2_int), .ext_int(lk.ext_int), .periph_int(lk.periph_int),
    .reset_req(lk.reset_req), .wdt1_reset(lk.wdt1_reset), .wdt2_reset(lk.wdt2_reset));
  // ************************************************
  // Tasks
  // ************************************************
  task automatic stop_test();
    if (fails == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_time(input int got, input int lo, input int hi);
    total_checks++;
    if (got < lo || got > hi) begin
      fails++;
      $display("ERROR t=%0t cycles=%h limit=%h", $time, got, lo);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge mclk);
      k++;
    end
    if (pready !== 1'b1) begin
      fails++;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (8) @(posedge mclk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk_val(rdat, exp);
  endtask
  task automatic pulse(input int k);
    @(posedge mclk);
    src <= 8'h01 << k;
    repeat (8) @(posedge mclk);
    src <= 8'h00;
    repeat (8) @(posedge mclk);
  endtask
  task automatic stop_wait();
    n = 0;
    while (lk.cpu_clk_en !== 1'b1 && n < 40000) begin
      @(negedge mclk);
      n++;
    end
    @(posedge mclk);
    src <= 8'h00;
  endtask
  function automatic logic [31:0] gate_exp(input logic [9:0] c);
    gate_exp = {25'h0, c[9], c[8], c[7], c[6], c[5] & c[2], c[2] | (c[3] & c[4]), c[0] & c[1]};
  endfunction
  // ************************************************
  // Clock, watchdog and tests
  // ************************************************
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    #(25 * 45000);
    fails++;
    stop_test();
  end
  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    src = 8'h00;
    fails = 0;
    total_checks = 0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    rd_chk(sscm_pkg::OFS_CLOCK_CONTROL, 32'h0);
    rd_chk(sscm_pkg::OFS_POWER_SAVE, 32'h1);
    rd_chk(sscm_pkg::OFS_STAB_SELECT, 32'h5);
    rd_chk(sscm_pkg::OFS_STATUS, 32'h0);
    wr(8'h20, 32'h5);
    chk_val({31'h0, rerr}, 32'h1);
    rd_chk(8'h20, 32'h0);
    wr(sscm_pkg::OFS_CLOCK_CONTROL, 32'h0a);
    rd_chk(sscm_pkg::OFS_STATUS, 32'h1);
    chk_val({30'h0, on_subclock, lk.sys_on_sub}, 32'h3);
    wr(sscm_pkg::OFS_CLOCK_CONTROL, 32'h1a);
    chk_val({31'h0, lk.main_osc_run}, 32'h0);
    for (int i = 0; i < 10; i++) begin
      wr(sscm_pkg::OFS_PERIPH_CFG, {22'h0, cfgs[i]});
      chk_val({24'h0, lk.gate_en}, gate_exp(cfgs[i]));
    end
    for (int k = 0; k < 4; k++) begin
      wr(sscm_pkg::OFS_POWER_SAVE, 32'h2);
      rd_chk(sscm_pkg::OFS_STATUS, 32'h2);
      chk_val({29'h0, cpu_running, lk.cpu_clk_en, lk.periph_clk_en}, 32'h0);
      pulse(k);
      rd_chk(sscm_pkg::OFS_STATUS, 32'h1);
    end
    wr(sscm_pkg::OFS_POWER_SAVE, 32'h2);
    pulse(7);
    rd_chk(sscm_pkg::OFS_STATUS, 32'h2);
    clk_en <= 1'b0;
    pulse(0);
    clk_en <= 1'b1;
    rd_chk(sscm_pkg::OFS_STATUS, 32'h2);
    pulse(4);
    rd_chk(sscm_pkg::OFS_STATUS, 32'h0);
    apb(1'b0, sscm_pkg::OFS_CLOCK_CONTROL, 32'h0);
    chk_val(rdat & 32'h18, 32'h0);
    wr(sscm_pkg::OFS_CLOCK_CONTROL, 32'h0a);
    wr(sscm_pkg::OFS_POWER_SAVE, 32'h2);
    pulse(6);
    rd_chk(sscm_pkg::OFS_STATUS, 32'h0);
    wr(sscm_pkg::OFS_CLOCK_CONTROL, 32'h1a);
    wr(sscm_pkg::OFS_CLOCK_CONTROL, 32'h0a);
    repeat (1100) @(posedge mclk);
    wr(sscm_pkg::OFS_CLOCK_CONTROL, 32'h02);
    rd_chk(sscm_pkg::OFS_STATUS, 32'h0);
    wr(sscm_pkg::OFS_CLOCK_CONTROL, 32'h0a);
    pulse(5);
    rd_chk(sscm_pkg::OFS_STATUS, 32'h0);
    wr(sscm_pkg::OFS_STAB_SELECT, 32'h0);
    wr(sscm_pkg::OFS_POWER_SAVE, 32'h5);
    rd_chk(sscm_pkg::OFS_STATUS, 32'h3);
    @(posedge mclk);
    src <= 8'h01;
    stop_wait();
    chk_time(n, 1024, 1040);
    wr(sscm_pkg::OFS_STAB_SELECT, 32'h0);
    wr(sscm_pkg::OFS_POWER_SAVE, 32'h5);
    @(posedge mclk);
    src <= 8'h10;
    repeat (3) @(posedge mclk);
    src <= 8'h00;
    stop_wait();
    chk_time(n, 32768, 32784);
    rd_chk(sscm_pkg::OFS_STAB_SELECT, 32'h5);
    stop_test();
  end
endmodule // test_standby_subclock_mode_control
